// file: pkg/pmx_pkg.sv
/*
 file holds: constants for the paged memory expansion windows block.
 assumes: included before all design files; no imports, names are used package-qualified.
*/
package pmx_pkg;
	// ==========================================================
	// register offsets (byte addresses on the register port)
	localparam logic [7:0] off_line_assign = 8'h2d;
	localparam logic [7:0] off_win_size = 8'h56;
	localparam logic [7:0] off_win_base = 8'h57;
	localparam logic [7:0] off_bank_one = 8'h58;
	localparam logic [7:0] off_bank_two = 8'h59;
	localparam logic [7:0] off_mem_config = 8'h3f;
	localparam logic [7:0] off_nv_map = 8'h37;
	// ==========================================================
	// reset values
	localparam logic [7:0] rst_line_assign = 8'h00;
	localparam logic [7:0] rst_win_size = 8'h00;
	localparam logic [7:0] rst_win_base = 8'h00;
	localparam logic [7:0] rst_bank = 8'h00;
	localparam logic [7:0] rst_nv_map = 8'h00;
	localparam logic [1:0] rst_mem_config = 2'h0;
	// ==========================================================
	// writable masks (unimplemented bits read zero)
	localparam logic [7:0] mask_line_assign = 8'h3f;
	localparam logic [7:0] mask_win_size = 8'hf3;
	localparam logic [7:0] mask_win_base = 8'hee;
	localparam logic [7:0] mask_bank = 8'h7e;
	localparam logic [7:0] mask_nv_map = 8'hf0;
	// ==========================================================
	// field positions
	localparam int pos_size_one = 0;
	localparam int pos_size_two = 4;
	localparam int pos_cs_expand = 6;
	localparam int pos_base_one = 1;
	localparam int pos_base_two = 5;
	localparam int pos_bank_lsb = 1;
	localparam int pos_nv_pos = 4;
	localparam int pos_prog_en = 1;
	localparam int pos_nv_en = 0;
	// ==========================================================
	// window size codes and a window base code
	localparam logic [1:0] size_off = 2'h0;
	localparam logic [1:0] size_8k = 2'h1;
	localparam logic [1:0] size_16k = 2'h2;
	localparam logic [1:0] size_32k = 2'h3;
	localparam logic [2:0] base_quarter = 3'h2;
	// ==========================================================
	// operating modes sampled at reset release
	typedef enum logic [1:0] {
		pmx_mode_single,
		pmx_mode_expanded,
		pmx_mode_boot,
		pmx_mode_test
	} pmx_mode_t;
endpackage

// file: design/pmx_window_match.sv
/*
 file holds: one window comparator, yielding hit and the bank-line substitution.
 assumes: combinational; fed from registers and the cpu address on the same clock.
*/
module pmx_window_match (
	input wire logic [1:0] size_code, // window size field
	input wire logic [2:0] base_top, // window base field
	input wire logic [5:0] bank, // bank select value
	input wire logic [15:0] cpu_addr, // cpu address
	output logic hit, // address inside window
	output logic [5:0] lines, // value for expansion lines 18..13
	output logic [2:0] used // which of lines 15..13 the window drives
);
	// ==========================================================
	// base compare and bank placement
	always_comb begin
		hit = 1'b0;
		lines = 6'h00;
		used = 3'h0;
		case (size_code)
			pmx_pkg::size_8k: begin
				hit = (cpu_addr[15:13] == base_top);
				lines = bank;
				used = 3'h7;
			end
			pmx_pkg::size_16k: begin
				hit = (cpu_addr[15:14] == base_top[2:1]);
				lines = {bank[5:1], cpu_addr[13]};
				used = 3'h6;
			end
			pmx_pkg::size_32k: begin
				if (base_top[2]) begin
					hit = cpu_addr[15];
					lines = {bank[5:2], cpu_addr[14:13]};
					used = 3'h4;
				end else if (base_top[1]) begin
					hit = (cpu_addr[15:14] == 2'h1) || (cpu_addr[15:14] == 2'h2);
					lines = {bank[5:2], ~cpu_addr[14], cpu_addr[13]};
					used = 3'h6;
				end else begin
					hit = ~cpu_addr[15];
					lines = {bank[5:2], cpu_addr[14:13]};
					used = 3'h4;
				end
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end
endmodule

// file: design/pmx_expansion.sv
/*
 file holds: top of the paged memory expansion block: registers, window
 priority, pin muxing and on-chip resource decode.
 assumes: single clk, async active-low reset; cpu address is synchronous to clk;
 mode straps arrive from pins and are synchronised here.
*/
// Local design decision: the address-and-strobe port.
module pmx_expansion (
	input wire logic clk, // 125 MHz clock
	input wire logic rst_b, // async reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic [15:0] cpu_addr, // cpu address, same clock
	input wire logic mode_pin_a, // mode strap a, asynchronous
	input wire logic mode_pin_b, // mode strap b, asynchronous
	input wire logic internal_hit, // cpu address hits registers or RAM
	output logic [5:0] expansion_bank_lines, // pin values for lines 18..13
	output logic [5:0] expansion_line_oe, // pin driven as address line
	output logic [15:0] mem_addr_low, // resolved address 15..0 to pins
	output logic external_select, // access goes to external memory
	output logic prog_mem_select, // on-chip program memory answers
	output logic nonvolatile_select, // on-chip nonvolatile memory answers
	output logic [1:0] cs_expand_sel, // chip selects decode expanded address
	output logic window_active // either window hit
);
	// ==========================================================
	// declarations
	logic [1:0] mode_meta;
	logic [1:0] mode_sync;
	logic rst_seen;
	logic [7:0] port_g_line_assignment;
	logic [7:0] window_size_register;
	logic [7:0] window_base_register;
	logic [7:0] window_one_bank_select;
	logic [7:0] window_two_bank_select;
	logic [7:0] nonvolatile_map;
	logic program_memory_enable;
	logic data_nonvolatile_enable;
	logic hit_one;
	logic hit_two;
	logic [5:0] lines_one;
	logic [5:0] lines_two;
	logic [2:0] used_one;
	logic [2:0] used_two;
	logic [5:0] next_lines;
	logic [5:0] next_oe;
	logic [15:0] next_addr_low;
	logic next_prog;
	logic next_nv;
	logic next_ext;
	logic [7:0] next_rdata;
	logic [3:0] nonvolatile_map_position;

	// ==========================================================
	// register read decode, shared by the read port
	function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] la,
		input logic [7:0] sz, input logic [7:0] bs, input logic [7:0] b1,
		input logic [7:0] b2, input logic [7:0] nv, input logic pe, input logic ne);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			pmx_pkg::off_line_assign: r = la & pmx_pkg::mask_line_assign;
			pmx_pkg::off_win_size: r = sz & pmx_pkg::mask_win_size;
			pmx_pkg::off_win_base: r = bs & pmx_pkg::mask_win_base;
			pmx_pkg::off_bank_one: r = b1 & pmx_pkg::mask_bank;
			pmx_pkg::off_bank_two: r = b2 & pmx_pkg::mask_bank;
			pmx_pkg::off_nv_map: r = nv & pmx_pkg::mask_nv_map;
			pmx_pkg::off_mem_config: r = {6'h00, pe, ne};
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// ==========================================================
	// strap pair to operating mode
	function automatic pmx_pkg::pmx_mode_t strap_mode(input logic [1:0] s);
		pmx_pkg::pmx_mode_t m;
		case (s)
			2'h0: m = pmx_pkg::pmx_mode_single;
			2'h1: m = pmx_pkg::pmx_mode_expanded;
			2'h2: m = pmx_pkg::pmx_mode_boot;
			default: m = pmx_pkg::pmx_mode_test;
		endcase
		return m;
	endfunction

	// ==========================================================
	// strap synchroniser: two flops before any logic looks
	// not reset, so the straps are already settled when reset lifts
	always_ff @(posedge clk) begin
		mode_meta <= {mode_pin_b, mode_pin_a};
		mode_sync <= mode_meta;
	end

	// ==========================================================
	// marks the first edge after reset release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_seen <= 1'b0;
		end else begin
			rst_seen <= 1'b1;
		end
	end

	// ==========================================================
	// memory enables: program enable forced from single or test mode out of reset, then both writable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			program_memory_enable <= pmx_pkg::rst_mem_config[pmx_pkg::pos_prog_en];
			data_nonvolatile_enable <= pmx_pkg::rst_mem_config[pmx_pkg::pos_nv_en];
		end else if (!rst_seen) begin
			case (strap_mode(mode_sync))
				pmx_pkg::pmx_mode_single: program_memory_enable <= 1'b1;
				pmx_pkg::pmx_mode_test: program_memory_enable <= 1'b0;
				default: program_memory_enable <= program_memory_enable;
			endcase
		end else if (reg_wr && reg_addr == pmx_pkg::off_mem_config) begin
			program_memory_enable <= reg_wdata[pmx_pkg::pos_prog_en];
			data_nonvolatile_enable <= reg_wdata[pmx_pkg::pos_nv_en];
		end
	end

	// ==========================================================
	// window configuration registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port_g_line_assignment <= pmx_pkg::rst_line_assign;
			window_size_register <= pmx_pkg::rst_win_size;
			window_base_register <= pmx_pkg::rst_win_base;
			window_one_bank_select <= pmx_pkg::rst_bank;
			window_two_bank_select <= pmx_pkg::rst_bank;
			nonvolatile_map <= pmx_pkg::rst_nv_map;
		end else if (reg_wr) begin
			case (reg_addr)
				pmx_pkg::off_line_assign:
					port_g_line_assignment <= reg_wdata & pmx_pkg::mask_line_assign;
				pmx_pkg::off_win_size:
					window_size_register <= reg_wdata & pmx_pkg::mask_win_size;
				pmx_pkg::off_win_base:
					window_base_register <= reg_wdata & pmx_pkg::mask_win_base;
				pmx_pkg::off_bank_one:
					window_one_bank_select <= reg_wdata & pmx_pkg::mask_bank;
				pmx_pkg::off_bank_two:
					window_two_bank_select <= reg_wdata & pmx_pkg::mask_bank;
				pmx_pkg::off_nv_map:
					nonvolatile_map <= reg_wdata & pmx_pkg::mask_nv_map;
				default: nonvolatile_map <= nonvolatile_map;
			endcase
		end
	end

	// ==========================================================
	// read port: data in the cycle after the strobe, zero otherwise
	always_comb begin
		next_rdata = read_reg(reg_addr, port_g_line_assignment, window_size_register,
			window_base_register, window_one_bank_select, window_two_bank_select,
			nonvolatile_map, program_memory_enable, data_nonvolatile_enable);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// the two window comparators
	pmx_window_match u_win_one (
		.size_code(window_size_register[pmx_pkg::pos_size_one +: 2]),
		.base_top(window_base_register[pmx_pkg::pos_base_one +: 3]),
		.bank(window_one_bank_select[pmx_pkg::pos_bank_lsb +: 6]),
		.cpu_addr(cpu_addr),
		.hit(hit_one),
		.lines(lines_one),
		.used(used_one)
	);

	pmx_window_match u_win_two (
		.size_code(window_size_register[pmx_pkg::pos_size_two +: 2]),
		.base_top(window_base_register[pmx_pkg::pos_base_two +: 3]),
		.bank(window_two_bank_select[pmx_pkg::pos_bank_lsb +: 6]),
		.cpu_addr(cpu_addr),
		.hit(hit_two),
		.lines(lines_two),
		.used(used_two)
	);

	assign nonvolatile_map_position = nonvolatile_map[pmx_pkg::pos_nv_pos +: 4];

	// ==========================================================
	// expansion line value, priority and pin substitution
	always_comb begin
		logic [5:0] win_lines;
		logic [2:0] low_used;
		logic in_prog;
		logic in_nv;
		win_lines = 6'h00;
		in_prog = 1'b0;
		in_nv = 1'b0;
		low_used = used_one | used_two;
		if (hit_one) begin
			win_lines = lines_one;
		end else if (hit_two) begin
			win_lines = lines_two;
		end
		next_lines = win_lines;
		next_addr_low = cpu_addr;
		for (int i = 0; i < 3; i++) begin
			if (!low_used[i]) begin
				next_lines[i] = cpu_addr[13 + i];
			end else if ((hit_one || hit_two) && port_g_line_assignment[i]) begin
				next_addr_low[13 + i] = win_lines[i];
			end else begin
				next_addr_low[13 + i] = cpu_addr[13 + i];
			end
		end
		next_oe = port_g_line_assignment[5:0];
		// program memory sits high, from address a000 upward
		in_prog = program_memory_enable && (cpu_addr >= 16'ha000);
		in_nv = data_nonvolatile_enable && (cpu_addr[15:12] == nonvolatile_map_position)
			&& (cpu_addr[11:0] >= 12'hd80);
		next_nv = in_nv && !internal_hit;
		next_prog = in_prog && !internal_hit && !in_nv
			&& (!(hit_one || hit_two) || win_lines[5:3] == 3'h0);
		next_ext = !internal_hit && !next_nv && !next_prog;
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			expansion_bank_lines <= 6'h00;
			expansion_line_oe <= 6'h00;
			mem_addr_low <= 16'h0000;
			external_select <= 1'b0;
			prog_mem_select <= 1'b0;
			nonvolatile_select <= 1'b0;
			cs_expand_sel <= 2'h0;
			window_active <= 1'b0;
		end else begin
			expansion_bank_lines <= next_lines & port_g_line_assignment[5:0];
			expansion_line_oe <= next_oe;
			mem_addr_low <= next_addr_low;
			external_select <= next_ext;
			prog_mem_select <= next_prog;
			nonvolatile_select <= next_nv;
			cs_expand_sel <= window_size_register[pmx_pkg::pos_cs_expand +: 2];
			window_active <= hit_one || hit_two;
		end
	end
endmodule

// file: tb/pmx_expansion_monitor.sv
/*
 holds: port checker for the expansion block, bound to its top.
 assumes: one clock, rst_b active low, outputs lag cpu_addr by one clock.
*/
module pmx_expansion_monitor (
	input wire logic clk, // clock
	input wire logic rst_b, // reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic [15:0] cpu_addr, // cpu address
	input wire logic internal_hit, // on-chip hit
	input wire logic [5:0] expansion_bank_lines, // lines 18..13
	input wire logic [5:0] expansion_line_oe, // line drive enables
	input wire logic [15:0] mem_addr_low, // resolved low address
	input wire logic external_select, // external access
	input wire logic prog_mem_select, // program memory answers
	input wire logic nonvolatile_select, // nonvolatile answers
	input wire logic [1:0] cs_expand_sel, // chip select address choice
	input wire logic window_active // a window hit
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// port relations
	property p_mask;
		(expansion_bank_lines & ~expansion_line_oe) == 6'h00;
	endproperty
	a_mask: assert property (p_mask) else $error("line driven on unassigned pin");
	property p_cs;
		reg_wr && reg_addr == pmx_pkg::off_win_size |-> ##2 cs_expand_sel == $past(reg_wdata[7:6], 2);
	endproperty
	a_cs: assert property (p_cs) else $error("chip select choice not taken");
	property p_unimpl;
		reg_rd && reg_addr == pmx_pkg::off_line_assign |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("assignment top bits not zero");
	property p_upper;
		$past(rst_b) && !window_active |-> expansion_bank_lines[5:3] == 3'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper lines live outside windows");
	property p_low;
		$past(rst_b) |-> mem_addr_low[12:0] == $past(cpu_addr[12:0]);
	endproperty
	a_low: assert property (p_low) else $error("low address not passed");
	property p_pass;
		$past(rst_b) && !window_active |-> mem_addr_low == $past(cpu_addr);
	endproperty
	a_pass: assert property (p_pass) else $error("address changed outside windows");
	property p_internal;
		$past(rst_b) && $past(internal_hit) |-> !external_select;
	endproperty
	a_internal: assert property (p_internal) else $error("external beat internal");
	property p_prog;
		prog_mem_select && window_active |-> expansion_bank_lines[5:3] == 3'h0;
	endproperty
	a_prog: assert property (p_prog) else $error("program memory in upper bank");
	// main scenarios reached
	c_win: cover property (window_active);
	c_prog: cover property (prog_mem_select);
	c_nv: cover property (nonvolatile_select);
endmodule

bind pmx_expansion pmx_expansion_monitor u_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_addr(cpu_addr), .internal_hit(internal_hit), .expansion_bank_lines(expansion_bank_lines),
	.expansion_line_oe(expansion_line_oe), .mem_addr_low(mem_addr_low),
	.external_select(external_select), .prog_mem_select(prog_mem_select),
	.nonvolatile_select(nonvolatile_select), .cs_expand_sel(cs_expand_sel),
	.window_active(window_active));

// file: tb/pmx_paged_mem.sv
/*
 holds: model of the paged external memory behind the expansion pins.
 assumes: unassigned expansion pins have pull-downs; idle bus reads as all ones.
*/
module pmx_paged_mem (
	input wire logic [5:0] pin_lines, // expansion pin values
	input wire logic [5:0] pin_oe, // pin carries an address line
	input wire logic [15:0] addr_low, // low address pins
	input wire logic sel, // external access
	output logic [18:0] phys_addr // physical address seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// undriven pins fall to zero; unselected memory sees no address
	always_comb begin
		phys_addr = sel ? {pin_lines[5:3] & pin_oe[5:3], addr_low} : 19'h7ffff;
	end
endmodule

// file: tb/paged_memory_expansion_windows_tb.sv
/*
 holds: self-checking bench for the expansion block with a paged memory model.
 assumes: 125 MHz clock, register port with read data one cycle after the strobe.
*/
module paged_memory_expansion_windows_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, reg_wr, reg_rd, mode_pin_a, mode_pin_b, internal_hit;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [15:0] cpu_addr, mem_addr_low;
	logic [5:0] expansion_bank_lines, expansion_line_oe;
	logic external_select, prog_mem_select, nonvolatile_select, window_active;
	logic [1:0] cs_expand_sel;
	logic [18:0] phys_addr;
	logic [31:0] r, q;
	logic [7:0] offs [7], masks [7];
	int errors, compares;
	pmx_expansion dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
		.mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .internal_hit(internal_hit),
		.expansion_bank_lines(expansion_bank_lines), .expansion_line_oe(expansion_line_oe),
		.mem_addr_low(mem_addr_low), .external_select(external_select),
		.prog_mem_select(prog_mem_select), .nonvolatile_select(nonvolatile_select),
		.cs_expand_sel(cs_expand_sel), .window_active(window_active));
	pmx_paged_mem u_mem (.pin_lines(expansion_bank_lines), .pin_oe(expansion_line_oe),
		.addr_low(mem_addr_low), .sel(external_select), .phys_addr(phys_addr));
	// ==========================================================
	// clock, verdict and bus tasks
	always #4 clk = ~clk;
	task automatic end_sim;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic put_addr(input logic [15:0] a);
		@(posedge clk);
		cpu_addr <= a;
		@(posedge clk);
		#1;
	endtask
	task automatic do_reset(input logic [1:0] m);
		{mode_pin_b, mode_pin_a} <= m;
		rst_b <= 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// expected {hit, lines 18..13} of one window
	function automatic logic [6:0] win_exp(input logic [1:0] sz, input logic [2:0] bs,
		input logic [5:0] bk, input logic [15:0] a);
		case (sz)
			2'h1: win_exp = {a[15:13] == bs, bk};
			2'h2: win_exp = {a[15:14] == bs[2:1], bk[5:1], a[13]};
			2'h3: win_exp = (bs[2:1] == 2'h1) ? {a[15] ^ a[14], bk[5:2], ~a[14], a[13]}
				: {a[15] == bs[2], bk[5:2], a[14:13]};
			default: win_exp = 7'h00;
		endcase
	endfunction
	// program both windows, present one address, compare the pins
	task automatic run_case(input logic [1:0] s1, s2, input logic [2:0] b1, b2,
		input logic [5:0] k1, k2, asg, input logic [15:0] a);
		logic [6:0] e1, e2;
		logic [5:0] el;
		logic [1:0] cs;
		q = $urandom;
		cs = q[1:0];
		wr(pmx_pkg::off_line_assign, {2'h0, asg});
		wr(pmx_pkg::off_win_size, {cs, s2, 2'h0, s1});
		wr(pmx_pkg::off_win_base, {b2, 1'b0, b1, 1'b0});
		wr(pmx_pkg::off_bank_one, {1'b0, k1, 1'b0});
		wr(pmx_pkg::off_bank_two, {1'b0, k2, 1'b0});
		put_addr(a);
		e1 = win_exp(s1, b1, k1, a);
		e2 = win_exp(s2, b2, k2, a);
		el = e1[6] ? e1[5:0] : e2[5:0];
		chk("cs_expand_sel", cs, cs_expand_sel);
		chk("window_active", e1[6] | e2[6], window_active);
		chk("line_oe", asg, expansion_line_oe);
		if (e1[6] | e2[6]) begin
			chk("bank_lines", el & asg, expansion_bank_lines);
			if (asg == 6'h3f) begin
				chk("mem_addr_low", {el[2:0], a[12:0]}, mem_addr_low);
			end
			if (asg == 6'h3f && external_select === 1'b1) begin
				chk("phys_addr", {el, a[12:0]}, phys_addr);
			end
		end else begin
			chk("upper_lines", 3'h0, expansion_bank_lines[5:3]);
			chk("mem_addr_low", a, mem_addr_low);
			if (s1 == 2'h0 && s2 == 2'h0) begin
				chk("bank_lines", {3'h0, a[15:13]} & asg, expansion_bank_lines);
			end
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		clk = 0;
		rst_b = 0;
		reg_wr = 0;
		reg_rd = 0;
		reg_addr = 0;
		reg_wdata = 0;
		cpu_addr = 0;
		mode_pin_a = 0;
		mode_pin_b = 0;
		internal_hit = 0;
		errors = 0;
		compares = 0;
		r = $urandom(32'h30abd3c4);
		offs = '{pmx_pkg::off_line_assign, pmx_pkg::off_win_size, pmx_pkg::off_win_base,
			pmx_pkg::off_bank_one, pmx_pkg::off_bank_two, pmx_pkg::off_nv_map, 8'h00};
		masks = '{pmx_pkg::mask_line_assign, pmx_pkg::mask_win_size, pmx_pkg::mask_win_base,
			pmx_pkg::mask_bank, pmx_pkg::mask_bank, pmx_pkg::mask_nv_map, 8'h00};
		do_reset(2'h0);
		rd(pmx_pkg::off_mem_config, d);
		chk("prog_en single", 1'b1, d[1]);
		wr(pmx_pkg::off_line_assign, 8'hff);
		do_reset(2'h3);
		rd(pmx_pkg::off_mem_config, d);
		chk("prog_en test", 1'b0, d[1]);
		do_reset(2'h1);
		for (int i = 0; i < 7; i++) begin
			rd(offs[i], d);
			chk("reset value", 8'h00, d);
			wr(offs[i], 8'hff);
			rd(offs[i], d);
			chk("written value", masks[i], d);
		end
		run_case(2'h1, 2'h0, 3'h1, 3'h0, 6'h05, 6'h00, 6'h3f, 16'h2000);
		run_case(2'h3, 2'h0, 3'h2, 3'h0, 6'h2a, 6'h00, 6'h3f, 16'h4000);
		run_case(2'h3, 2'h0, 3'h3, 3'h0, 6'h15, 6'h00, 6'h3f, 16'hbfff);
		run_case(2'h1, 2'h2, 3'h2, 3'h2, 6'h11, 6'h22, 6'h3f, 16'h4000);
		run_case(2'h1, 2'h2, 3'h2, 3'h2, 6'h11, 6'h22, 6'h3f, 16'h6000);
		run_case(2'h0, 2'h0, 3'h0, 3'h0, 6'h00, 6'h00, 6'h2b, 16'he5a5);
		for (int i = 0; i < 150; i++) begin
			r = $urandom;
			q = $urandom;
			run_case(r[1:0], r[3:2], r[6:4], r[9:7], r[15:10], r[21:16],
				r[22] ? 6'h3f : r[28:23], q[15:0]);
		end
		wr(pmx_pkg::off_mem_config, 8'h02);
		run_case(2'h1, 2'h0, 3'h5, 3'h0, 6'h00, 6'h00, 6'h3f, 16'ha000);
		chk("prog bank zero", 1'b1, prog_mem_select);
		run_case(2'h1, 2'h0, 3'h5, 3'h0, 6'h08, 6'h00, 6'h3f, 16'ha000);
		chk("prog upper bank", 1'b0, prog_mem_select);
		wr(pmx_pkg::off_mem_config, 8'h00);
		run_case(2'h0, 2'h0, 3'h0, 3'h0, 6'h00, 6'h00, 6'h3f, 16'ha000);
		chk("prog removed", 1'b0, prog_mem_select);
		chk("prog removed ext", 1'b1, external_select);
		wr(pmx_pkg::off_nv_map, 8'h30);
		wr(pmx_pkg::off_mem_config, 8'h01);
		put_addr(16'h3d80);
		chk("nv present", 1'b1, nonvolatile_select);
		wr(pmx_pkg::off_mem_config, 8'h00);
		put_addr(16'h3d80);
		chk("nv absent", 1'b0, nonvolatile_select);
		run_case(2'h1, 2'h0, 3'h0, 3'h0, 6'h09, 6'h00, 6'h3f, 16'h0010);
		@(posedge clk);
		internal_hit <= 1'b1;
		put_addr(16'h0010);
		chk("internal wins", 1'b0, external_select);
		@(posedge clk);
		internal_hit <= 1'b0;
		end_sim;
	end
	// watchdog against a hang, well beyond the few thousand cycles the tests take
	initial begin
		#200000;
		errors++;
		end_sim;
	end
endmodule
